// ==== bss_defines.svh ====
// timing counts and reset values for the backup supply switchover block
`ifndef BSS_DEFINES_SVH
`define BSS_DEFINES_SVH
`define BSS_FILTER_SAMPLES 2
`define BSS_LOSS_FLAG_RESET 1'b1
`endif

// ==== bss_pkg.sv ====
// types shared by the backup supply switchover block
package bss_pkg;
  typedef enum logic [1:0] {
    BSS_UNARMED,
    BSS_NORMAL,
    BSS_BACKUP
  } bss_mode_t;

  typedef struct packed {
    logic vddBelowBatHys;
    logic vddAboveBatHys;
    logic vddBelowTrip;
    logic vddAboveTripHys;
    logic vddPresent;
    logic batPresent;
  } bss_cmp_t;

  typedef struct packed {
    logic       alarmAct;
    logic       freqEn;
    logic [3:0] freqSel;
    logic       freqBatEn;
  } bss_ctl_t;
endpackage : bss_pkg

// ==== bss_switchover.sv ====
// power mode control, bus gating and open-drain pins of the backup supply switchover
`timescale 1ns/1ps
`include "bss_defines.svh"
module bss_switchover #(
  parameter int FILTER_SAMPLES = `BSS_FILTER_SAMPLES
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              clkEn,
  input  wire bss_pkg::bss_cmp_t cmpIn,
  input  wire bss_pkg::bss_ctl_t ctl,
  input  wire logic              low_power_switch_select,
  input  wire logic              clockRegWrite,
  input  wire logic              lossFlagClear,
  input  wire logic [15:0]       xtalDiv,
  output logic                   backupMode,
  output logic                   batteryDraw,
  output logic                   trip_threshold_monitor_en,
  output logic                   busEnable,
  output logic                   timeRun,
  output logic                   total_power_loss_flag,
  output logic                   alarmIrq_o,
  output logic                   alarmIrq_oe,
  output logic                   freq_out_pin_o,
  output logic                   freq_out_pin_oe
);
  import bss_pkg::*;

  typedef struct packed {
    bss_cmp_t  s1;
    bss_cmp_t  s2;
    bss_mode_t mode;
    logic [3:0] agree;
    logic      lossFlag;
    logic      timeHold;
    logic      irqDrv;
    logic      fDrv;
  } bss_state_t;

  bss_state_t st;
  bss_state_t next_st;
  logic       wantBackup;
  logic       wantNormal;
  logic       pinsLive;
  logic       lost;

  // one more agreeing sample finishes the filter
  function automatic logic filterDone(input logic [3:0] agree);
    return (32'(agree) + 32'd1 >= 32'(FILTER_SAMPLES));
  endfunction : filterDone

  // entry and exit share one counter so both directions filter alike
  function automatic logic [3:0] nextAgree(input logic want, input logic [3:0] agree);
    if (!want || filterDone(agree)) begin
      return 4'h0;
    end
    return agree + 4'h1;
  endfunction : nextAgree

  always_comb begin
    // low power mode ignores the trip comparator entirely
    if (low_power_switch_select) begin
      wantBackup = st.s2.vddBelowBatHys;
    end else begin
      wantBackup = st.s2.vddBelowBatHys && st.s2.vddBelowTrip;
    end
    wantNormal = st.s2.vddAboveBatHys
                 || (!low_power_switch_select && st.s2.vddAboveTripHys);
  end

  always_comb begin
    next_st = st;
    next_st.s1 = cmpIn;
    next_st.s2 = st.s1;
    // both supplies gone counts as a fresh power-up, seen after the synchroniser
    lost = !st.s2.vddPresent && !st.s2.batPresent;
    if (clockRegWrite) begin
      next_st.timeHold = 1'b0;
    end
    if (lossFlagClear) begin
      next_st.lossFlag = 1'b0;
    end
    // set wins over a clear or a clock write in the same cycle
    if (lost) begin
      next_st.lossFlag = 1'b1;
      next_st.timeHold = 1'b1;
    end
    case (st.mode)
      BSS_UNARMED: begin
        // battery untouched until main supply seen once
        if (st.s2.vddPresent) begin
          next_st.mode = BSS_NORMAL;
        end
        next_st.agree = 4'h0;
      end
      BSS_NORMAL: begin
        next_st.agree = nextAgree(wantBackup, st.agree);
        if (wantBackup && filterDone(st.agree)) begin
          next_st.mode = BSS_BACKUP;
        end
      end
      BSS_BACKUP: begin
        next_st.agree = nextAgree(wantNormal, st.agree);
        if (wantNormal && filterDone(st.agree)) begin
          next_st.mode = BSS_NORMAL;
        end
      end
      default: next_st.mode = BSS_UNARMED;
    endcase
    // re-arm: battery stays untouched until main supply returns
    if (lost) begin
      next_st.mode  = BSS_UNARMED;
      next_st.agree = 4'h0;
    end
    // other pins keep working in backup when their enable allows
    pinsLive = (st.mode != BSS_BACKUP) || ctl.freqBatEn;
    next_st.irqDrv = ctl.alarmAct && !ctl.freqEn && pinsLive;
    next_st.fDrv   = ctl.freqEn && pinsLive && !xtalDiv[ctl.freqSel];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{s1: '0, s2: '0, mode: BSS_UNARMED, agree: 4'h0,
              lossFlag: `BSS_LOSS_FLAG_RESET, timeHold: 1'b1,
              irqDrv: 1'b0, fDrv: 1'b0};
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign backupMode                = (st.mode == BSS_BACKUP);
  assign batteryDraw               = (st.mode == BSS_BACKUP);
  assign trip_threshold_monitor_en = !low_power_switch_select;
  assign busEnable                 = (st.mode == BSS_NORMAL);
  assign timeRun                   = !st.timeHold;
  assign total_power_loss_flag     = st.lossFlag;
  assign alarmIrq_o                = 1'b0;
  assign alarmIrq_oe               = st.irqDrv;
  assign freq_out_pin_o            = 1'b0;
  assign freq_out_pin_oe           = st.fDrv;

  // mode control, bus gating and time run
  a_unarmed_no_draw: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st.mode == BSS_UNARMED |-> !batteryDraw)
    else $error("battery drawn before arming");

  a_loss_rearms: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && lost |=> !batteryDraw && !busEnable)
    else $error("still armed after total loss");

  a_backup_bus_off: assert property (
    @(posedge mclk) disable iff (!arst_n)
    backupMode |-> !busEnable)
    else $error("bus live in backup");

  a_time_keeps_run: assert property (
    @(posedge mclk) disable iff (!arst_n)
    timeRun && !lost |=> timeRun)
    else $error("time stopped without loss");

  a_enter_needs_cond: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && st.mode == BSS_NORMAL && !wantBackup |=> !backupMode)
    else $error("backup entered without condition");

  a_leave_needs_cond: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && backupMode && !wantNormal && !lost |=> backupMode)
    else $error("left backup early");

  a_lp_ignores_trip: assert property (
    @(posedge mclk) disable iff (!arst_n)
    low_power_switch_select |-> !trip_threshold_monitor_en)
    else $error("trip monitor on");

  a_filter_entry: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $rose(backupMode) |-> $past(wantBackup) && (FILTER_SAMPLES < 2 || $past(wantBackup, 2)))
    else $error("unfiltered entry");

  a_frozen_hold: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !clkEn |=> $stable(st))
    else $error("state moved while disabled");

  // power loss and time hold
  a_hold_until_write: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !timeRun && !(clkEn && clockRegWrite) |=> !timeRun)
    else $error("time ran early");

  a_loss_flag_set: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && lost |=> total_power_loss_flag && !timeRun)
    else $error("loss flag not set");

  // open-drain pins
  a_irq_open_drain: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !alarmIrq_o && !freq_out_pin_o)
    else $error("open drain driven high");

  a_pins_off_backup: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && backupMode && !ctl.freqBatEn |=> !alarmIrq_oe && !freq_out_pin_oe)
    else $error("pin live in backup while disabled");

  a_freq_blocks_alarm: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && ctl.freqEn |=> !alarmIrq_oe)
    else $error("alarm pin live with frequency output on");

  a_alarm_follows_act: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && ctl.alarmAct && !ctl.freqEn && !backupMode |=> alarmIrq_oe)
    else $error("alarm not pulled low");

  a_freq_follows_tap: assert property (
    @(posedge mclk) disable iff (!arst_n)
    clkEn && ctl.freqEn && !backupMode && !xtalDiv[ctl.freqSel] |=> freq_out_pin_oe)
    else $error("frequency pin missed low phase");

  c_enter_backup: cover property (@(posedge mclk) $rose(backupMode));
  c_leave_backup: cover property (@(posedge mclk) $fell(backupMode));
  c_lp_entry: cover property (@(posedge mclk) low_power_switch_select && $rose(backupMode));
  c_time_start: cover property (@(posedge mclk) $rose(timeRun));
  c_total_loss: cover property (@(posedge mclk) disable iff (!arst_n) clkEn && lost);
endmodule : bss_switchover

// ==== bss_supply_model.sv ====
// comparator front end model: supply levels in mV to comparator decisions
`timescale 1ns/1ps
module bss_supply_model #(
  parameter int TRIP_MV    = 2200,
  parameter int BAT_HYS_MV = 50,
  parameter int TRIP_HYS   = 30,
  parameter int PRESENT_MV = 1000
) (
  input  wire logic signed [13:0] vddMv,
  input  wire logic signed [13:0] batMv,
  output bss_pkg::bss_cmp_t       cmpOut
);
  import bss_pkg::*;
  // ideal comparators, so only the design's filtering decides timing
  assign cmpOut = '{vddMv < batMv - BAT_HYS_MV, vddMv > batMv + BAT_HYS_MV,
    vddMv < TRIP_MV, vddMv > TRIP_MV + TRIP_HYS, vddMv > PRESENT_MV, batMv > PRESENT_MV};
endmodule : bss_supply_model

// ==== tb.sv ====
// self-checking bench for the backup supply switchover
`timescale 1ns/1ps
module tb;
  import bss_pkg::*;
  logic mclk = 0, arst_n = 0, clkEn = 1, lps = 0, regWr = 0, flagClr = 0;
  logic [15:0] xtalDiv = 16'h0000;
  logic signed [13:0] vdd = 0, bat = 3000;
  bss_cmp_t cmp;
  bss_ctl_t ctl = '0;
  logic bkp, draw, tripEn, busEn, run, loss, irqO, irqOe, foO, foOe, fo1;
  int err_count = 0, n_compared = 0;
  bss_supply_model sup (.vddMv(vdd), .batMv(bat), .cmpOut(cmp));
  bss_switchover uut (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .cmpIn(cmp), .ctl(ctl),
    .low_power_switch_select(lps), .clockRegWrite(regWr), .lossFlagClear(flagClr),
    .xtalDiv(xtalDiv), .backupMode(bkp), .batteryDraw(draw), .trip_threshold_monitor_en(tripEn),
    .busEnable(busEn), .timeRun(run), .total_power_loss_flag(loss), .alarmIrq_o(irqO),
    .alarmIrq_oe(irqOe), .freq_out_pin_o(foO), .freq_out_pin_oe(foOe));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // sync plus filter takes about four edges; eight leaves margin
  task automatic sup_set(input int v, input int b, input logic expBkp);
    @(posedge mclk);
    vdd <= 14'(v);
    bat <= 14'(b);
    repeat (8) @(posedge mclk);
    #1;
    chk("backupMode", bkp, expBkp);
    chk("busEnable", busEn, !expBkp);
  endtask : sup_set
  task automatic t_power_up;
    #1;
    chk("batteryDraw", draw, 0);
    chk("lossFlag", loss, 1);
    chk("timeRun", run, 0);
    // battery alone must not arm the switchover
    repeat (8) @(posedge mclk);
    #1;
    chk("batteryDraw", draw, 0);
    chk("busEnable", busEn, 0);
    sup_set(3300, 3000, 0);
    @(posedge mclk) regWr <= 1;
    @(posedge mclk) regWr <= 0;
    flagClr <= 1;
    @(posedge mclk) flagClr <= 0;
    repeat (3) @(posedge mclk);
    #1;
    chk("timeRun", run, 1);
    chk("lossFlag", loss, 0);
  endtask : t_power_up
  task automatic t_switch;
    sup_set(2500, 3000, 0);
    @(posedge mclk) vdd <= 2000;
    @(posedge mclk) vdd <= 3300;
    sup_set(3300, 3000, 0);
    sup_set(2000, 3000, 1);
    chk("batteryDraw", draw, 1);
    chk("timeRun", run, 1);
    sup_set(2210, 3000, 1);
    sup_set(2240, 3000, 0);
    sup_set(2000, 2100, 1);
    sup_set(2160, 2100, 0);
  endtask : t_switch
  task automatic t_low_power;
    sup_set(3300, 3000, 0);
    @(posedge mclk) lps <= 1;
    sup_set(2900, 3000, 1);
    chk("tripMonitor", tripEn, 0);
    sup_set(3300, 3000, 0);
    @(posedge mclk) lps <= 0;
  endtask : t_low_power
  task automatic t_freeze;
    @(posedge mclk) clkEn <= 0;
    vdd <= 2000;
    repeat (8) @(posedge mclk);
    #1;
    chk("frozenMode", bkp, 0);
    @(posedge mclk) clkEn <= 1;
    repeat (8) @(posedge mclk);
    #1;
    chk("backupMode", bkp, 1);
    sup_set(3300, 3000, 0);
  endtask : t_freeze
  task automatic t_pins;
    // configuration while main supply is up, except freqBatEn, which is set while in backup
    @(posedge mclk) ctl.alarmAct <= 1;
    repeat (3) @(posedge mclk);
    #1;
    chk("alarmOe", irqOe, 1);
    chk("alarmOut", irqO, 0);
    @(posedge mclk) ctl.freqEn <= 1;
    xtalDiv <= 16'hFFFF;
    repeat (3) @(posedge mclk);
    #1;
    chk("alarmOe", irqOe, 0);
    fo1 = foOe;
    @(posedge mclk) xtalDiv <= 16'h0000;
    repeat (3) @(posedge mclk);
    #1;
    chk("freqToggles", fo1 !== foOe, 1);
    chk("freqOut", foO, 0);
    @(posedge mclk) ctl.freqSel <= 4'h3;
    xtalDiv <= 16'h0008;
    repeat (3) @(posedge mclk);
    #1;
    chk("freqTap", foOe, 0);
    @(posedge mclk) ctl.freqEn <= 0;
    sup_set(2000, 3000, 1);
    chk("alarmOeBackup", irqOe, 0);
    @(posedge mclk) ctl.freqBatEn <= 1;
    repeat (3) @(posedge mclk);
    #1;
    chk("alarmOeBackup", irqOe, 1);
    sup_set(3300, 3000, 0);
    @(posedge mclk) ctl <= '0;
  endtask : t_pins
  task automatic t_total_loss;
    @(posedge mclk);
    vdd <= 0;
    bat <= 0;
    repeat (8) @(posedge mclk);
    #1;
    chk("lossFlag", loss, 1);
    chk("timeRun", run, 0);
    chk("batteryDraw", draw, 0);
    chk("busEnable", busEn, 0);
    sup_set(3300, 3000, 0);
    chk("lossFlag", loss, 1);
    chk("timeRun", run, 0);
    @(posedge mclk) regWr <= 1;
    @(posedge mclk) regWr <= 0;
    repeat (2) @(posedge mclk);
    #1;
    chk("timeRun", run, 1);
  endtask : t_total_loss
  initial forever #12.5 mclk = ~mclk;
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1;
    t_power_up();
    t_switch();
    t_low_power();
    t_freeze();
    t_pins();
    t_total_loss();
    test_done();
  end
endmodule : tb
